// ---- cwu_ctrl.sv ----
// Purpose: Complementary waveform unit with dead-band and auto-shutdown.
// Assumes: Pins and sleep come from outside and are synchronised here.
// Notes: Generator rate is a tick enable; fast rate ticks every cycle.
`timescale 1ns/1ps
module cwu_ctrl #(
  parameter int NIN = 4,
  parameter int DIV = cwu_pkg::SLOW_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [NIN-1:0] wave_in,
  input wire logic [cwu_pkg::NSD-1:0] shutdown_in,
  input wire logic sleep_in,
  output logic output_a_pin,
  output logic output_a_pin_oe,
  output logic output_b_pin,
  output logic output_b_pin_oe,
  output logic fast_osc_hold,
  output logic irq
);
  // Configuration registers.
  logic [7:0] out_ctrl_r;
  logic [cwu_pkg::SEL_W-1:0] in_sel_r;
  logic [cwu_pkg::NSD-1:0] sd_src_r;
  logic lvl_a_r;
  logic lvl_b_r;
  logic arsen_r;
  logic flag_r;
  logic flag_nxt;
  logic [cwu_pkg::DB_W-1:0] rise_db_r;
  logic [cwu_pkg::DB_W-1:0] fall_db_r;
  logic [cwu_pkg::NIRQ-1:0] int_stat_r;
  logic [cwu_pkg::NIRQ-1:0] int_en_r;
  logic [7:0] rdata_r;
  // Synchronisers.
  logic [NIN-1:0] in_s1_r;
  logic [NIN-1:0] in_s2_r;
  logic [cwu_pkg::NSD-1:0] sd_s1_r;
  logic [cwu_pkg::NSD-1:0] sd_s2_r;
  logic sleep_s1_r;
  logic sleep_s2_r;
  // Tick generation and waveform state.
  logic [7:0] div_r;
  logic slow_tick;
  logic tick;
  logic wave;
  logic wave_prev_r;
  logic wave_rise;
  cwu_pkg::cwu_state_t state_r;
  cwu_pkg::cwu_state_t state_nxt;
  logic [1:0] db_in;
  logic [1:0] db_out;
  logic [cwu_pkg::DB_W-1:0] db_cnt [2];
  logic enable;
  logic sd_any;
  logic wr_sd;
  logic ev_shut;
  logic ev_resume;
  logic pin_a_r;
  logic pin_b_r;
  logic oe_a_r;
  logic oe_b_r;
  logic hold_r;
  logic irq_r;

  assign enable = out_ctrl_r[cwu_pkg::OC_EN];
  assign wr_sd = wr_stb && (addr == cwu_pkg::ADDR_SD_CTRL);

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      sd_s1_r <= '0;
      sd_s2_r <= '0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      in_s1_r <= wave_in;
      in_s2_r <= in_s1_r;
      sd_s1_r <= shutdown_in;
      sd_s2_r <= sd_s1_r;
      sleep_s1_r <= sleep_in;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // Slow tick divider; the generator ignores the sleep state entirely.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (div_r == 8'(DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign slow_tick = (div_r == 8'(DIV - 1));
  // Selected generator rate, independent of any system clock.
  assign tick = (out_ctrl_r[cwu_pkg::OC_CLK_SEL] == cwu_pkg::CLK_FAST)
    ? 1'b1 : slow_tick;

  // Selected input source and its rising edge at the generator rate.
  assign wave = in_s2_r[in_sel_r];
  assign wave_rise = wave && !wave_prev_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_prev_r <= 1'b0;
    end else if (tick) begin
      wave_prev_r <= wave;
    end
  end

  // Any selected shutdown source high.
  assign sd_any = |(sd_s2_r & sd_src_r);

  // Flag update: a set always wins over a clear in the same cycle.
  always_comb begin
    flag_nxt = flag_r;
    if (sd_any) begin
      flag_nxt = 1'b1;
    end else if (wr_sd && wdata[cwu_pkg::SD_FLAG]) begin
      flag_nxt = 1'b1;
    end else if (wr_sd && !wdata[cwu_pkg::SD_FLAG]) begin
      flag_nxt = 1'b0;
    end else if (arsen_r) begin
      flag_nxt = 1'b0;
    end
  end

  // Shutdown control register, with the flag kept live by hardware.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
      arsen_r <= 1'b0;
      lvl_a_r <= 1'b0;
      lvl_b_r <= 1'b0;
      sd_src_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_sd) begin
        arsen_r <= wdata[cwu_pkg::SD_ARSEN];
        lvl_a_r <= wdata[cwu_pkg::SD_LVL_A];
        lvl_b_r <= wdata[cwu_pkg::SD_LVL_B];
        sd_src_r <= wdata[cwu_pkg::SD_SRC_LO +: cwu_pkg::NSD];
      end
    end
  end

  // Remaining configuration registers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ctrl_r <= cwu_pkg::RST_ZERO;
      in_sel_r <= '0;
      rise_db_r <= cwu_pkg::DB_ZERO;
      fall_db_r <= cwu_pkg::DB_ZERO;
      int_en_r <= '0;
    end else if (wr_stb) begin
      case (addr)
        cwu_pkg::ADDR_OUT_CTRL: begin
          out_ctrl_r <= wdata;
        end
        cwu_pkg::ADDR_IN_SEL: begin
          in_sel_r <= wdata[cwu_pkg::SEL_W-1:0];
        end
        cwu_pkg::ADDR_RISE_DB: begin
          rise_db_r <= wdata[cwu_pkg::DB_W-1:0];
        end
        cwu_pkg::ADDR_FALL_DB: begin
          fall_db_r <= wdata[cwu_pkg::DB_W-1:0];
        end
        cwu_pkg::ADDR_INT_EN: begin
          int_en_r <= wdata[cwu_pkg::NIRQ-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Waveform state: starts in override, waits for a rising input edge.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cwu_pkg::CWU_OVR: begin
        if (enable && !flag_r) begin
          state_nxt = cwu_pkg::CWU_WAIT;
        end
      end
      cwu_pkg::CWU_WAIT: begin
        if (tick && wave_rise) begin
          state_nxt = cwu_pkg::CWU_RUN;
        end
      end
      cwu_pkg::CWU_RUN: begin
        state_nxt = cwu_pkg::CWU_RUN;
      end
      default: begin
        state_nxt = cwu_pkg::CWU_OVR;
      end
    endcase
    if (!enable || flag_r) begin
      state_nxt = cwu_pkg::CWU_OVR;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cwu_pkg::CWU_OVR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Dead-band inputs: A follows the input, B its complement.
  assign db_in[0] = wave && (state_r == cwu_pkg::CWU_RUN);
  assign db_in[1] = !wave && (state_r == cwu_pkg::CWU_RUN);
  assign db_cnt[0] = rise_db_r;
  assign db_cnt[1] = fall_db_r;

  // One dead-band delay per output delays its turn-on edge.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_db
      cwu_deadband #(
        .W(cwu_pkg::DB_W)
      ) u_db (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .level_in(db_in[g]),
        .count(db_cnt[g]),
        .level_out(db_out[g])
      );
    end
  endgenerate

  // Output pins: override levels bypass polarity, drive gated by enables.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_r <= 1'b0;
      pin_b_r <= 1'b0;
      oe_a_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      oe_a_r <= enable && out_ctrl_r[cwu_pkg::OC_OE_A];
      oe_b_r <= enable && out_ctrl_r[cwu_pkg::OC_OE_B];
      if (state_r != cwu_pkg::CWU_RUN) begin
        pin_a_r <= lvl_a_r;
        pin_b_r <= lvl_b_r;
      end else begin
        pin_a_r <= db_out[0] ^ out_ctrl_r[cwu_pkg::OC_POL_A];
        pin_b_r <= db_out[1] ^ out_ctrl_r[cwu_pkg::OC_POL_B];
      end
    end
  end

  // Keep the fast oscillator alive in sleep while it clocks the generator.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= enable && sleep_s2_r &&
        (out_ctrl_r[cwu_pkg::OC_CLK_SEL] == cwu_pkg::CLK_FAST);
    end
  end

  // Events: flag rising, and normal operation resuming.
  assign ev_shut = flag_nxt && !flag_r;
  assign ev_resume = (state_nxt == cwu_pkg::CWU_RUN) &&
    (state_r == cwu_pkg::CWU_WAIT);

  // Sticky status; a new event beats a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= '0;
    end else begin
      if (wr_stb && (addr == cwu_pkg::ADDR_INT_CLR)) begin
        int_stat_r[cwu_pkg::IRQ_SHUT] <= ev_shut ||
          (int_stat_r[cwu_pkg::IRQ_SHUT] && !wdata[cwu_pkg::IRQ_SHUT]);
        int_stat_r[cwu_pkg::IRQ_RESUME] <= ev_resume ||
          (int_stat_r[cwu_pkg::IRQ_RESUME] &&
           !wdata[cwu_pkg::IRQ_RESUME]);
      end else begin
        int_stat_r[cwu_pkg::IRQ_SHUT] <=
          int_stat_r[cwu_pkg::IRQ_SHUT] || ev_shut;
        int_stat_r[cwu_pkg::IRQ_RESUME] <=
          int_stat_r[cwu_pkg::IRQ_RESUME] || ev_resume;
      end
    end
  end

  // Level interrupt while any enabled status bit is set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  // Read data, valid in the cycle after the read strobe only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= cwu_pkg::RST_ZERO;
    end else if (!rd_stb) begin
      rdata_r <= cwu_pkg::RST_ZERO;
    end else begin
      rdata_r <= cwu_pkg::RST_ZERO;
      case (addr)
        cwu_pkg::ADDR_OUT_CTRL: begin
          rdata_r <= out_ctrl_r;
        end
        cwu_pkg::ADDR_IN_SEL: begin
          rdata_r[cwu_pkg::SEL_W-1:0] <= in_sel_r;
        end
        cwu_pkg::ADDR_SD_CTRL: begin
          rdata_r[cwu_pkg::SD_FLAG] <= flag_r;
          rdata_r[cwu_pkg::SD_ARSEN] <= arsen_r;
          rdata_r[cwu_pkg::SD_LVL_B] <= lvl_b_r;
          rdata_r[cwu_pkg::SD_LVL_A] <= lvl_a_r;
          rdata_r[cwu_pkg::SD_SRC_LO +: cwu_pkg::NSD] <= sd_src_r;
        end
        cwu_pkg::ADDR_RISE_DB: begin
          rdata_r[cwu_pkg::DB_W-1:0] <= rise_db_r;
        end
        cwu_pkg::ADDR_FALL_DB: begin
          rdata_r[cwu_pkg::DB_W-1:0] <= fall_db_r;
        end
        cwu_pkg::ADDR_INT_STAT: begin
          rdata_r[cwu_pkg::NIRQ-1:0] <= int_stat_r;
        end
        cwu_pkg::ADDR_INT_EN: begin
          rdata_r[cwu_pkg::NIRQ-1:0] <= int_en_r;
        end
        default: begin
          rdata_r <= cwu_pkg::RST_ZERO;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign rdata = rdata_r;
  assign output_a_pin = pin_a_r;
  assign output_b_pin = pin_b_r;
  assign output_a_pin_oe = oe_a_r;
  assign output_b_pin_oe = oe_b_r;
  assign fast_osc_hold = hold_r;
  assign irq = irq_r;
endmodule : cwu_ctrl

// ---- cwu_pkg.sv ----
// Purpose: Shared constants and types of the complementary waveform unit.
// Assumes: 8-bit register data, 3-bit register index, one 125 MHz clock.
// Notes: Summary of operation
package cwu_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_OUT_CTRL = 3'h0;
  localparam logic [2:0] ADDR_IN_SEL = 3'h1;
  localparam logic [2:0] ADDR_SD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_RISE_DB = 3'h3;
  localparam logic [2:0] ADDR_FALL_DB = 3'h4;
  localparam logic [2:0] ADDR_INT_STAT = 3'h5;
  localparam logic [2:0] ADDR_INT_CLR = 3'h6;
  localparam logic [2:0] ADDR_INT_EN = 3'h7;
  // Field positions of the output control register.
  localparam int OC_OE_A = 0;
  localparam int OC_OE_B = 1;
  localparam int OC_POL_A = 3;
  localparam int OC_POL_B = 4;
  localparam int OC_CLK_SEL = 5;
  localparam int OC_EN = 7;
  // Field positions of the shutdown control register.
  localparam int SD_SRC_LO = 0;
  localparam int SD_LVL_A = 4;
  localparam int SD_LVL_B = 5;
  localparam int SD_ARSEN = 6;
  localparam int SD_FLAG = 7;
  // Interrupt status bit positions.
  localparam int IRQ_SHUT = 0;
  localparam int IRQ_RESUME = 1;
  // Widths of fields.
  localparam int DATA_W = 8;
  localparam int DB_W = 6;
  localparam int SEL_W = 2;
  localparam int NSD = 2;
  localparam int NIRQ = 2;
  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [5:0] DB_ZERO = 6'h00;
  // Clock select value that picks the fast oscillator rate.
  localparam logic CLK_FAST = 1'b0;
  // Default divider ratio for the slow tick source.
  localparam int SLOW_DIV = 4;
  // Waveform states.
  typedef enum logic [1:0] {
    CWU_OVR = 2'b00,
    CWU_WAIT = 2'b01,
    CWU_RUN = 2'b10
  } cwu_state_t;
endpackage : cwu_pkg

// ---- cwu_deadband.sv ----
// Purpose: Delays the turn-on edge of one output by a programmed tick count.
// Assumes: tick is a one-cycle enable on ref_clk.
// Notes: The turn-off edge passes through on the next clock.
`timescale 1ns/1ps
module cwu_deadband #(
  parameter int W = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic level_in,
  input wire logic [W-1:0] count,
  output logic level_out
);
  logic [W-1:0] cnt_r;
  logic out_r;

  // Count ticks while the level is high, then raise the output.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (!level_in) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (tick && !out_r) begin
      if (cnt_r >= count) begin
        out_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  assign level_out = out_r;
endmodule : cwu_deadband

// ---- cwu_ctrl_chk.sv ----
// Purpose: Port-level checks of the complementary waveform unit.
// Assumes: Register shadows are rebuilt from the register port.
// Notes: Most checks wait three cycles after any write for it to land.
`timescale 1ns/1ps
module cwu_ctrl_chk #(
  parameter int NIN = 4,
  parameter int DIV = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [NIN-1:0] wave_in,
  input wire logic [cwu_pkg::NSD-1:0] shutdown_in,
  input wire logic sleep_in,
  input wire logic output_a_pin,
  input wire logic output_a_pin_oe,
  input wire logic output_b_pin,
  input wire logic output_b_pin_oe,
  input wire logic fast_osc_hold,
  input wire logic irq
);
  logic [7:0] oc_sh, sd_sh, ie_sh;
  logic [1:0] is_sh, wr_age;
  logic [2:0] sd_cnt, sl_cnt;
  logic ovr_r, wv_prev;
  wire logic sd_hit = |(shutdown_in & sd_sh[1:0]);
  wire logic wv = wave_in[is_sh];

  // Shadows of the written registers and the age of the last write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_sh <= 8'h00;
      sd_sh <= 8'h00;
      ie_sh <= 8'h00;
      is_sh <= 2'h0;
      wr_age <= 2'h3;
    end else begin
      wr_age <= wr_stb ? 2'h0 : (wr_age == 2'h3 ? wr_age : wr_age + 2'h1);
      if (wr_stb && addr == cwu_pkg::ADDR_OUT_CTRL) oc_sh <= wdata;
      if (wr_stb && addr == cwu_pkg::ADDR_SD_CTRL) sd_sh <= wdata;
      if (wr_stb && addr == cwu_pkg::ADDR_INT_EN) ie_sh <= wdata;
      if (wr_stb && addr == cwu_pkg::ADDR_IN_SEL) is_sh <= wdata[1:0];
    end
  end

  // Runs of a masked shutdown source and of sleep, saturating at 7.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_cnt <= 3'h0;
      sl_cnt <= 3'h0;
    end else begin
      sd_cnt <= !sd_hit ? 3'h0 : (sd_cnt == 3'h7 ? sd_cnt : sd_cnt + 3'h1);
      sl_cnt <= !sleep_in ? 3'h0 : (sl_cnt == 3'h7 ? sl_cnt : sl_cnt + 3'h1);
    end
  end

  // Override is owed from reset or a shutdown until the next input rise.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_r <= 1'b1;
      wv_prev <= 1'b0;
    end else begin
      ovr_r <= (sd_cnt == 3'h4) | (ovr_r & !(wv & !wv_prev));
      wv_prev <= wv;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (
    !$past(rd_stb) |-> rdata == 8'h00) else $error("stray read data");
  a_oe_a_gate: assert property (
    wr_age == 2'h3 |-> output_a_pin_oe == (oc_sh[7] & oc_sh[0]))
    else $error("output A enable wrong");
  a_oe_b_gate: assert property (
    wr_age == 2'h3 |-> output_b_pin_oe == (oc_sh[7] & oc_sh[1]))
    else $error("output B enable wrong");
  a_ovr_a_level: assert property (
    ovr_r && wr_age == 2'h3 |-> output_a_pin == sd_sh[4])
    else $error("output A not at its override level");
  a_ovr_b_level: assert property (
    ovr_r && wr_age == 2'h3 |-> output_b_pin == sd_sh[5])
    else $error("output B not at its override level");
  a_flag_held_set: assert property (
    rd_stb && addr == cwu_pkg::ADDR_SD_CTRL && sd_cnt > 3'h3 |=> rdata[7])
    else $error("shutdown flag clear while a source is high");
  a_osc_hold_on: assert property (
    wr_age == 2'h3 && sl_cnt > 3'h3 && oc_sh[7] &&
    oc_sh[5] == cwu_pkg::CLK_FAST |-> fast_osc_hold)
    else $error("fast oscillator released in sleep");
  a_osc_hold_off: assert property (
    wr_age == 2'h3 && !oc_sh[7] |-> !fast_osc_hold)
    else $error("fast oscillator held while disabled");
  a_irq_masked: assert property (
    wr_age == 2'h3 && ie_sh[1:0] == 2'h0 |-> !irq)
    else $error("interrupt raised while masked");
endmodule : cwu_ctrl_chk

bind cwu_ctrl cwu_ctrl_chk #(.NIN(NIN), .DIV(DIV)) u_cwu_ctrl_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .wave_in(wave_in),
  .shutdown_in(shutdown_in), .sleep_in(sleep_in),
  .output_a_pin(output_a_pin), .output_a_pin_oe(output_a_pin_oe),
  .output_b_pin(output_b_pin), .output_b_pin_oe(output_b_pin_oe),
  .fast_osc_hold(fast_osc_hold), .irq(irq));

// ---- cwu_stage.sv ----
// Purpose: Model of the switching stage driven by the two outputs.
// Assumes: Each gate line carries a pull-down resistor.
// Notes: A released pin reads low, never its last driven value.
`timescale 1ns/1ps
module cwu_stage (
  input wire logic output_a_pin,
  input wire logic output_a_pin_oe,
  input wire logic output_b_pin,
  input wire logic output_b_pin_oe,
  output logic gate_hi,
  output logic gate_lo
);
  // Gate levels seen by the stage, pulled low while a pin is released.
  assign gate_hi = output_a_pin_oe ? output_a_pin : 1'b0;
  assign gate_lo = output_b_pin_oe ? output_b_pin : 1'b0;
endmodule : cwu_stage

// ---- tb_cwu_ctrl.sv ----
// Purpose: Self-checking bench of the complementary waveform unit.
// Assumes: Fast clock select ticks every cycle, slow every DIV cycles.
// Notes: Dead-band, input choice and levels come from a fixed seed.
`timescale 1ns/1ps
module tb_cwu_ctrl;
  localparam int DIV = 2;
  logic ref_clk, rst_n, wr_stb, rd_stb, sleep_in;
  logic [2:0] addr;
  logic [7:0] wdata, d;
  logic [3:0] wave_in;
  logic [1:0] shutdown_in, sel, lv;
  logic [5:0] rdb;
  logic [31:0] tmp;
  integer seed = 50;
  int errors = 0;
  int check_count = 0;
  wire logic [7:0] rdata;
  wire logic a_pin, a_oe, b_pin, b_oe, hold, irq, gate_hi, gate_lo;

  cwu_ctrl #(.NIN(4), .DIV(DIV)) u_cwu_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .wave_in(wave_in),
    .shutdown_in(shutdown_in), .sleep_in(sleep_in),
    .output_a_pin(a_pin), .output_a_pin_oe(a_oe),
    .output_b_pin(b_pin), .output_b_pin_oe(b_oe),
    .fast_osc_hold(hold), .irq(irq));
  cwu_stage u_cwu_stage (.output_a_pin(a_pin), .output_a_pin_oe(a_oe),
    .output_b_pin(b_pin), .output_b_pin_oe(b_oe), .gate_hi(gate_hi),
    .gate_lo(gate_lo));

  // Expected shutdown control word from its fields.
  function automatic logic [7:0] sd_w(input logic f, input logic ars,
      input logic [1:0] lvl, input logic [1:0] m);
    return {f, ars, lvl, 2'b00, m};
  endfunction : sd_w

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk);
    v = rdata;
  endtask : rd

  // Compares a byte result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Compares a cycle count against a window.
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[FAIL] %0t latency %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Moves the selected input and counts cycles until a gate turns on.
  task automatic lat(input logic lvl, input logic lo_side, input int lo,
      input int hi);
    int c;
    c = 0;
    wave_in[sel] <= lvl;
    do begin
      @(posedge ref_clk);
      c++;
    end while ((lo_side ? gate_lo : gate_hi) !== 1'b1 && c < 300);
    chk_rng(c, lo, hi);
  endtask : lat

  // Overrides hold until a rise, then both dead-bands are timed.
  task automatic run_chk;
    repeat (6) @(posedge ref_clk);
    chk({6'h00, b_pin, a_pin}, 8'h00);
    lat(1'b1, 1'b0, rdb + 5, rdb + 7);
    lat(1'b0, 1'b1, 1, 8);
    chk({7'h00, gate_hi}, 8'h00);
  endtask : run_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Free-running 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    test_done;
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wave_in = 4'h0;
    shutdown_in = 2'h0;
    sleep_in = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk(d, 8'h00);
    end
    tmp = $random(seed);
    rdb = {2'b00, tmp[3:0]};
    sel = tmp[9:8];
    lv = tmp[5:4];
    // Set-up in the documented order, polarity on to test the overrides.
    wr(cwu_pkg::ADDR_OUT_CTRL, 8'h00);
    wr(cwu_pkg::ADDR_RISE_DB, {2'b00, rdb});
    wr(cwu_pkg::ADDR_FALL_DB, 8'h00);
    wr(cwu_pkg::ADDR_SD_CTRL, sd_w(1'b1, 1'b0, lv, 2'b01));
    wr(cwu_pkg::ADDR_IN_SEL, {6'h00, sel});
    wr(cwu_pkg::ADDR_INT_EN, 8'h03);
    wr(cwu_pkg::ADDR_OUT_CTRL, 8'h9b);
    rd(cwu_pkg::ADDR_RISE_DB, d);
    chk(d, {2'b00, rdb});
    repeat (8) begin
      tmp = $random(seed);
      @(posedge ref_clk);
      wave_in <= tmp[3:0];
    end
    @(posedge ref_clk);
    wave_in <= 4'h0;
    repeat (4) @(posedge ref_clk);
    chk({6'h00, b_pin, a_pin}, {6'h00, lv});
    // A clear while the source is high is refused.
    shutdown_in <= 2'b01;
    repeat (4) @(posedge ref_clk);
    wr(cwu_pkg::ADDR_SD_CTRL, sd_w(1'b0, 1'b0, 2'b00, 2'b01));
    rd(cwu_pkg::ADDR_SD_CTRL, d);
    chk(d, sd_w(1'b1, 1'b0, 2'b00, 2'b01));
    shutdown_in <= 2'b00;
    repeat (4) @(posedge ref_clk);
    wr(cwu_pkg::ADDR_OUT_CTRL, 8'h83);
    wr(cwu_pkg::ADDR_SD_CTRL, sd_w(1'b0, 1'b0, 2'b00, 2'b01));
    rd(cwu_pkg::ADDR_SD_CTRL, d);
    chk(d, sd_w(1'b0, 1'b0, 2'b00, 2'b01));
    run_chk;
    // Automatic restart; an unmasked source is ignored.
    wr(cwu_pkg::ADDR_SD_CTRL, sd_w(1'b0, 1'b1, 2'b00, 2'b10));
    shutdown_in <= 2'b01;
    repeat (4) @(posedge ref_clk);
    rd(cwu_pkg::ADDR_SD_CTRL, d);
    chk(d, sd_w(1'b0, 1'b1, 2'b00, 2'b10));
    shutdown_in <= 2'b10;
    repeat (4) @(posedge ref_clk);
    rd(cwu_pkg::ADDR_SD_CTRL, d);
    chk(d, sd_w(1'b1, 1'b1, 2'b00, 2'b10));
    shutdown_in <= 2'b00;
    repeat (4) @(posedge ref_clk);
    rd(cwu_pkg::ADDR_SD_CTRL, d);
    chk(d, sd_w(1'b0, 1'b1, 2'b00, 2'b10));
    run_chk;
    // Sleep keeps the fast oscillator while the fast rate is selected, and the waveform running.
    sleep_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({7'h00, hold}, 8'h01);
    lat(1'b1, 1'b0, rdb + 1, rdb + 8);
    wr(cwu_pkg::ADDR_OUT_CTRL, 8'ha3);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, hold}, 8'h00);
    lat(1'b0, 1'b1, DIV, 3 * DIV + 8);
    sleep_in <= 1'b0;
    // Polarity bits invert the running outputs: input low gives A high.
    wr(cwu_pkg::ADDR_OUT_CTRL, 8'h9b);
    repeat (3) @(posedge ref_clk);
    chk({6'h00, b_pin, a_pin}, 8'h01);
    // Events latch, obey the enable mask and clear by writing ones.
    rd(cwu_pkg::ADDR_INT_STAT, d);
    chk(d, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wr(cwu_pkg::ADDR_INT_EN, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    wr(cwu_pkg::ADDR_INT_EN, 8'h03);
    wr(cwu_pkg::ADDR_INT_CLR, 8'h03);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    rd(cwu_pkg::ADDR_INT_STAT, d);
    chk(d, 8'h00);
    test_done;
  end
endmodule : tb_cwu_ctrl
